/* hdl/net_ctrl_status_irq_flags.sv */
/*
 * status-flag and interrupt part of the network main control/status register,
 * with an axi4-lite slave, sticky event status, mask and level interrupt.
 * assumes the descriptor engines, mac and dma report events as one-cycle pulses.
 */
`timescale 1ns/1ps
module net_ctrl_status_irq_flags (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        io_bus_reset,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // events from the rest of the unit
   input  wire logic        tx_byte_sent,
   input  wire logic        tx_packet_end,
   input  wire logic        tx_own_done,
   input  wire logic        collision_in,
   input  wire logic        rx_no_buffer_drop,
   input  wire logic        internal_loopback,
   input  wire logic        dma_cycle_active,
   input  wire logic        dma_ready,
   input  wire logic        rx_last_desc_update,
   input  wire logic        rx_fail_stop,
   input  wire logic        tx_last_desc_update,
   input  wire logic        tx_fail_stop,
   input  wire logic        init_params_stored,
   input  wire logic        rx_start_on,
   input  wire logic        tx_start_on,
   // state to the rest of the unit
   output logic             stop_out,
   output logic             error_summary,
   output logic             rx_on,
   output logic             tx_on,
   output logic             irq_line_two,
   output logic [4:0]       priority_level,
   output logic [7:0]       irq_vector,
   output logic             irq
);
   import net_csr_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [6:0]  flags_reg;       // bits 14..8
   logic [6:0]  flag_set;
   logic [6:0]  stat_reg;
   logic [6:0]  mask_reg;
   logic        ien_reg;
   logic        stop_reg;
   logic        rxon_reg;
   logic        txon_reg;
   logic [10:0] tx_bytes_reg;
   logic        tx_timeout_flag_seen_reg;
   logic        hb_wait_reg;
   logic        hb_fail;
   logic        mem_fail;
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        wr_fire;
   logic        clr_all;
   logic        stop_wr;
   logic [15:0] main_view;
   logic        irq_sum;
   logic        err_sum;
   logic        wr_main;
   logic        wr_stat;
   logic        wr_mask;

   assign clr_all = !aresetn || io_bus_reset;

   // ------------------------------------------------------------
   // axi4-lite write channel
   // ------------------------------------------------------------
   // address and data are taken independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_main = wr_fire && aw_addr_reg == ADDR_MAIN_CSR;
   assign wr_stat = wr_fire && aw_addr_reg == ADDR_IRQ_STAT && w_strb_reg[0];
   assign wr_mask = wr_fire && aw_addr_reg == ADDR_IRQ_MASK && w_strb_reg[0];
   assign stop_wr = wr_main && w_strb_reg[0] && w_data_reg[BIT_STOP];

   // ready flags and write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OK;
      end else begin
         s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg == ADDR_MAIN_CSR || aw_addr_reg == ADDR_IRQ_STAT ||
                             aw_addr_reg == ADDR_IRQ_MASK || aw_addr_reg == ADDR_TX_BYTES)
                            ? RESP_OK : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // event detection
   // ------------------------------------------------------------
   // byte count of the packet in flight, tx_timeout_flag once per packet
   always_ff @(posedge aclk) begin
      if (clr_all || stop_reg || tx_packet_end) begin
         tx_bytes_reg  <= 11'h000;
         tx_timeout_flag_seen_reg <= 1'b0;
      end else if (tx_byte_sent) begin
         if (tx_bytes_reg != 11'h7ff) begin
            tx_bytes_reg <= tx_bytes_reg + 11'h001;
         end
         if (tx_bytes_reg == 11'(MAX_TX_BYTES - 1)) begin
            tx_timeout_flag_seen_reg <= 1'b1;
         end
      end
   end

   // heartbeat window opens when own transmission completes
   always_ff @(posedge aclk) begin
      if (clr_all || stop_reg || collision_in || hb_fail) begin
         hb_wait_reg <= 1'b0;
      end else if (tx_own_done) begin
         hb_wait_reg <= 1'b1;
      end
   end

   net_timeout_timer #(.LIMIT(HB_WAIT_CYC)) hb_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .arm     (hb_wait_reg && !collision_in),
      .expired (hb_fail)
   );

   net_timeout_timer #(.LIMIT(MEM_WAIT_CYC)) mem_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .arm     (dma_cycle_active && !dma_ready && !stop_reg),
      .expired (mem_fail)
   );

   // set sources for flags 14..8
   always_comb begin
      flag_set    = 7'h00;
      flag_set[6] = tx_byte_sent && !tx_timeout_flag_seen_reg &&
                    tx_bytes_reg == 11'(MAX_TX_BYTES - 1);
      flag_set[5] = hb_fail;
      flag_set[4] = rx_no_buffer_drop && !internal_loopback;
      flag_set[3] = mem_fail;
      flag_set[2] = rx_last_desc_update || rx_fail_stop;
      flag_set[1] = tx_last_desc_update || tx_fail_stop;
      flag_set[0] = init_params_stored;
   end

   // ------------------------------------------------------------
   // flags, enable, stop, receiver/transmitter on
   // ------------------------------------------------------------
   // one-to-clear with set winning; stop and resets clear everything
   always_ff @(posedge aclk) begin
      if (clr_all || stop_wr) begin
         flags_reg <= RST_FLAGS;
      end else begin
         flags_reg <= (flags_reg & ~((wr_main && w_strb_reg[1]) ? w_data_reg[14:8] : 7'h00))
                      | flag_set;
      end
   end

   // interrupt enable, read/write
   always_ff @(posedge aclk) begin
      if (clr_all || stop_wr) begin
         ien_reg <= 1'b0;
      end else if (wr_main && w_strb_reg[0]) begin
         ien_reg <= w_data_reg[BIT_IEN];
      end
   end

   // stop held after reset, cleared by start or init
   always_ff @(posedge aclk) begin
      if (clr_all) begin
         stop_reg <= 1'b1;
      end else if (stop_wr) begin
         stop_reg <= 1'b1;
      end else if (wr_main && w_strb_reg[0] && (w_data_reg[BIT_START] || w_data_reg[BIT_INIT])) begin
         stop_reg <= 1'b0;
      end
   end

   // receiver and transmitter on, dropped by memory timeout
   always_ff @(posedge aclk) begin
      if (clr_all || stop_wr || mem_fail) begin
         rxon_reg <= 1'b0;
         txon_reg <= 1'b0;
      end else begin
         if (rx_start_on) begin
            rxon_reg <= 1'b1;
         end
         if (tx_start_on) begin
            txon_reg <= 1'b1;
         end
      end
   end

   assign irq_sum = |(flags_reg & IRQ_SRC);
   assign err_sum = |(flags_reg & ERR_SRC);

   always_comb begin
      main_view            = 16'h0000;
      main_view[14:8]      = flags_reg;
      main_view[BIT_ERR]   = err_sum;
      main_view[BIT_IRQ]   = irq_sum;
      main_view[BIT_IEN]   = ien_reg;
      main_view[BIT_RXON]  = rxon_reg;
      main_view[BIT_TXON]  = txon_reg;
      main_view[BIT_STOP]  = stop_reg;
   end

   // ------------------------------------------------------------
   // sticky status and mask for the level interrupt
   // ------------------------------------------------------------
   // each flag event also latches here; write one clears, set wins
   always_ff @(posedge aclk) begin
      if (clr_all || stop_wr) begin
         stat_reg <= RST_FLAGS;
      end else begin
         stat_reg <= (stat_reg & ~(wr_stat ? w_data_reg[6:0] : 7'h00)) | flag_set;
      end
   end

   always_ff @(posedge aclk) begin
      if (clr_all) begin
         mask_reg <= RST_MASK;
      end else if (wr_mask) begin
         mask_reg <= w_data_reg[6:0];
      end
   end

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_line_two   <= 1'b0;
         irq            <= 1'b0;
         stop_out       <= 1'b1;
         error_summary  <= 1'b0;
         rx_on          <= 1'b0;
         tx_on          <= 1'b0;
         priority_level <= IRQ_LEVEL;
         irq_vector     <= IRQ_VECTOR;
      end else begin
         irq_line_two   <= irq_sum && ien_reg;
         irq            <= |(stat_reg & mask_reg);
         stop_out       <= stop_reg;
         error_summary  <= err_sum;
         rx_on          <= rxon_reg;
         tx_on          <= txon_reg;
         priority_level <= IRQ_LEVEL;
         irq_vector     <= IRQ_VECTOR;
      end
   end

   // ------------------------------------------------------------
   // axi4-lite read channel
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OK;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OK;
            unique case (s_axi_araddr)
               ADDR_MAIN_CSR: s_axi_rdata <= {16'h0000, main_view};
               ADDR_IRQ_STAT: s_axi_rdata <= {25'h0000000, stat_reg};
               ADDR_IRQ_MASK: s_axi_rdata <= {25'h0000000, mask_reg};
               ADDR_TX_BYTES: s_axi_rdata <= {21'h000000, tx_bytes_reg};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : net_ctrl_status_irq_flags

/* hdl/net_csr_pkg.sv */
/*
 * constants for the network main control/status flag block: register offsets,
 * bit positions, reset values, timing counts.
 * assumes a 20 mhz aclk and an axi4-lite master holding the register bus.
 */
package net_csr_pkg;
   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_MAIN_CSR = 8'h00; // net_main_ctrl_status
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h04; // sticky event status
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h08; // event mask
   localparam logic [7:0] ADDR_TX_BYTES = 8'h0c; // live transmit byte count
   // ------------------------------------------------------------
   // main register bit positions
   // ------------------------------------------------------------
   localparam int BIT_ERR   = 15;
   localparam int BIT_TX_TIMEOUT_FLAG  = 14;
   localparam int BIT_HBF   = 13;
   localparam int BIT_MISS  = 12;
   localparam int BIT_MEM   = 11;
   localparam int BIT_RXEV  = 10;
   localparam int BIT_TXEV  = 9;
   localparam int BIT_IDONE = 8;
   localparam int BIT_IRQ   = 7;
   localparam int BIT_IEN   = 6;
   localparam int BIT_RXON  = 5;
   localparam int BIT_TXON  = 4;
   localparam int BIT_STOP  = 2;
   localparam int BIT_START = 1;
   localparam int BIT_INIT  = 0;
   localparam int NUM_EV    = 7;  // flags 14..8
   localparam int EV_LSB    = 8;
   localparam logic [6:0] RST_FLAGS = 7'h00;
   localparam logic [6:0] IRQ_SRC   = 7'h5f; // all flags but heartbeat (bit 13)
   localparam logic [6:0] ERR_SRC   = 7'h78; // flags 14..11
   localparam logic [6:0] RST_MASK  = 7'h7f;
   // ------------------------------------------------------------
   // interrupt routing (line two, level 16, vector d5)
   // ------------------------------------------------------------
   localparam logic [4:0] IRQ_LEVEL  = 5'h10;
   localparam logic [7:0] IRQ_VECTOR = 8'hd5;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ          = 20_000_000;
   localparam int MAX_TX_BYTES    = 1519;
   localparam int HB_WAIT_NS      = 2000;   // 2 us
   localparam int MEM_WAIT_NS     = 25600;  // 25.6 us
   localparam int HB_WAIT_CYC     = (HB_WAIT_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int MEM_WAIT_CYC    = (MEM_WAIT_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam logic [2:0] RESP_OKAY   = 3'h0;
   localparam logic [1:0] RESP_OK     = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : net_csr_pkg

/* hdl/net_timeout_timer.sv */
/*
 * one-shot watchdog: counts while armed, pulses expired once at the limit.
 * assumes arm is a level held by the caller; dropping it restarts.
 */
`timescale 1ns/1ps
module net_timeout_timer #(
   parameter int LIMIT = 40
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic arm,
   output logic      expired
);
   logic [15:0] count_reg;
   logic        done_reg;

   // count up while armed, stop after expiry
   always_ff @(posedge aclk) begin
      if (!aresetn || !arm) begin
         count_reg <= 16'h0000;
         done_reg  <= 1'b0;
      end else if (!done_reg) begin
         if (count_reg == 16'(LIMIT - 1)) begin
            done_reg <= 1'b1;
         end
         count_reg <= count_reg + 16'h0001;
      end
   end

   assign expired = arm && !done_reg && (count_reg == 16'(LIMIT - 1));
endmodule : net_timeout_timer

/* tb/net_flags_checker.sv */
/*
 port checker: bus answers, timeouts, clears.
 assumes one aclk domain.
*/
`timescale 1ns/1ps
module net_flags_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        io_bus_reset,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        tx_byte_sent,
   input wire logic        tx_packet_end,
   input wire logic        tx_own_done,
   input wire logic        collision_in,
   input wire logic        rx_no_buffer_drop,
   input wire logic        internal_loopback,
   input wire logic        dma_cycle_active,
   input wire logic        dma_ready,
   input wire logic        stop_out,
   input wire logic        error_summary,
   input wire logic        rx_on,
   input wire logic        tx_on,
   input wire logic        irq_line_two,
   input wire logic [4:0]  priority_level,
   input wire logic [7:0]  irq_vector
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [11:0] bc_reg;
   logic [6:0]  hc_reg;
   logic [9:0]  mc_reg;
   // bytes of the packet under way
   always_ff @(posedge aclk) begin
      if (!aresetn || tx_packet_end) bc_reg <= '0;
      else if (tx_byte_sent) bc_reg <= bc_reg + 12'h001;
   end
   // cycles since own transmit end, no collision
   always_ff @(posedge aclk) begin
      if (!aresetn || collision_in) hc_reg <= '0;
      else if (tx_own_done) hc_reg <= 7'h01;
      else if (hc_reg != 7'h00 && hc_reg != 7'h7f) hc_reg <= hc_reg + 7'h01;
   end
   // unanswered memory cycles
   always_ff @(posedge aclk) begin
      if (!aresetn || !dma_cycle_active || dma_ready) mc_reg <= '0;
      else if (mc_reg != 10'h3ff) mc_reg <= mc_reg + 10'h001;
   end
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_wr_answer: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("write response missing");
   a_rd_answer: assert property (rd_take |=> s_axi_rvalid) else $error("read response missing");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rdata moved");
   a_bad_addr: assert property (rd_take and s_axi_araddr > 8'h0c |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("bad read");
   a_tx_timeout: assert property (tx_byte_sent && bc_reg == 12'h5ee |-> ##[1:3] error_summary)
      else $error("tx timeout");
   a_hb_fail: assert property (hc_reg == 7'h2d |-> error_summary) else $error("hb flag");
   a_mem_off: assert property (mc_reg == 10'h203 |-> error_summary && !rx_on && !tx_on)
      else $error("mem timeout");
   a_miss_err: assert property (rx_no_buffer_drop && !internal_loopback |-> ##[1:3] error_summary)
      else $error("miss flag");
   a_io_clear: assert property (io_bus_reset |-> ##2 (stop_out && !error_summary && !rx_on && !irq_line_two))
      else $error("io reset");
   a_route_fixed: assert property (aresetn && $past(aresetn, 2) |-> priority_level == 5'h10 && irq_vector == 8'hd5)
      else $error("routing");
endmodule : net_flags_checker

bind net_ctrl_status_irq_flags net_flags_checker net_flags_checker_inst (.*);

/* tb/net_unit_model.sv */
/*
 model of the unit: byte stream and buffer ram.
 assumes a one-cycle go; busy watched.
*/
`timescale 1ns/1ps
module net_unit_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        go,
   input  wire logic        slow,
   input  wire logic        stall,
   input  wire logic [11:0] n_bytes,
   input  wire logic        dma_cycle_active,
   output logic             tx_byte_sent,
   output logic             tx_packet_end,
   output logic             busy,
   output logic             dma_ready
);
   logic [11:0] left_reg;
   logic        gap_reg;
   logic [1:0]  wait_reg;
   // one byte a cycle, or every other cycle when slow, then packet end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         left_reg      <= '0;
         busy          <= 1'b0;
         gap_reg       <= 1'b0;
         tx_byte_sent  <= 1'b0;
         tx_packet_end <= 1'b0;
      end else begin
         tx_byte_sent  <= 1'b0;
         tx_packet_end <= 1'b0;
         gap_reg       <= slow & ~gap_reg;
         if (go && !busy) begin
            left_reg <= n_bytes;
            busy     <= 1'b1;
         end else if (busy && left_reg != 12'h000 && !gap_reg) begin
            tx_byte_sent <= 1'b1;
            left_reg     <= left_reg - 12'h001;
         end else if (busy && left_reg == 12'h000) begin
            tx_packet_end <= 1'b1;
            busy          <= 1'b0;
         end
      end
   end
   // ready three cycles into a memory cycle, never while stalled
   always_ff @(posedge aclk) begin
      if (!aresetn || !dma_cycle_active) begin
         wait_reg  <= 2'h0;
         dma_ready <= 1'b0;
      end else begin
         wait_reg  <= (wait_reg == 2'h2) ? wait_reg : wait_reg + 2'h1;
         dma_ready <= !stall && wait_reg == 2'h2;
      end
   end
endmodule : net_unit_model

/* tb/tb_net_ctrl_status_irq_flags.sv */
/*
 bench for the flag block over axi4-lite.
 assumes the bound checker and the unit model.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_net_ctrl_status_irq_flags;
   import net_csr_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0, io_bus_reset = 1'b0, collision_in = 1'b0, internal_loopback = 1'b0;
   logic        dma_cycle_active = 1'b0, go = 1'b0, slow = 1'b0, stall = 1'b0;
   logic [11:0] n_bytes = '0;
   logic [8:0]  ev = '0;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'h5ee149f5, d;
   logic [3:0]  s_axi_wstrb = '0;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        tx_byte_sent, tx_packet_end, busy, dma_ready, stop_out, error_summary, rx_on, tx_on, irq_line_two, irq;
   logic [4:0]  priority_level;
   logic [7:0]  irq_vector;
   int          n_mismatch = 0, comparisons = 0, cyc = 0;
   int          fidx [6] = '{2, 2, 1, 1, 0, 4};
   net_ctrl_status_irq_flags net_ctrl_status_irq_flags_inst (.rx_last_desc_update(ev[0]), .rx_fail_stop(ev[1]),
      .tx_last_desc_update(ev[2]), .tx_fail_stop(ev[3]), .init_params_stored(ev[4]), .rx_no_buffer_drop(ev[5]),
      .tx_own_done(ev[6]), .rx_start_on(ev[7]), .tx_start_on(ev[8]), .*);
   net_unit_model net_unit_model_inst (.*);
   always #25 aclk = ~aclk;
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // main register image: summary bits worked out from the flags
   function automatic logic [31:0] exp_main(input logic [6:0] fl);
      return {16'h0, |(fl & 7'h78), fl, |(fl & 7'h5f), 1'b1, 3'b000, 1'b0, 2'b00};
   endfunction : exp_main
   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   // write, optional receive event on the clear edge
   task automatic wr(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] s, input logic sev = 1'b0,
                     input logic [1:0] er = RESP_OK);
      logic ad, wd;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dd;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      ev[0] <= sev;
      do begin
         @(posedge aclk);
         ev[0] <= 1'b0;
      end while (!s_axi_bvalid);
      `CHK(s_axi_bresp, er)
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic chkreg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OK);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      `CHK(s_axi_rdata, e)
      `CHK(s_axi_rresp, er)
      s_axi_rready <= 1'b0;
   endtask : chkreg
   task automatic pulse(input int k);
      @(posedge aclk);
      ev[k] <= 1'b1;
      @(posedge aclk);
      ev[k] <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask : pulse
   task automatic send(input logic [11:0] n, input logic s);
      @(posedge aclk);
      n_bytes <= n;
      slow <= s;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      do @(posedge aclk); while (busy);
      repeat (4) @(posedge aclk);
   endtask : send
   // hang guard
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 12000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chkreg(ADDR_MAIN_CSR, 32'h4);
      chkreg(ADDR_IRQ_MASK, 32'h7f);
      chkreg(ADDR_IRQ_STAT, 32'h0);
      chkreg(8'h10, 32'h0, RESP_SLVERR);
      wr(8'h20, 32'h0, 4'hf, 1'b0, RESP_SLVERR);
      wr(ADDR_MAIN_CSR, 32'h80f2, 4'h3);
      chkreg(ADDR_MAIN_CSR, exp_main(7'h00));
      `CHK({priority_level, irq_vector}, 13'h10d5)
      for (int i = 0; i < 6; i++) begin
         pulse(i);
         chkreg(ADDR_MAIN_CSR, exp_main(7'h01 << fidx[i]));
         `CHK({irq_line_two, irq}, 2'b11)
         d = (xs() & 32'h7e00 & ~(32'h100 << fidx[i])) | 32'h40;
         wr(ADDR_MAIN_CSR, d, 4'h3);
         chkreg(ADDR_MAIN_CSR, exp_main(7'h01 << fidx[i]));
         wr(ADDR_MAIN_CSR, (32'h100 << fidx[i]) | 32'h40, 4'h3);
         wr(ADDR_IRQ_STAT, 32'h7f, 4'hf);
         chkreg(ADDR_MAIN_CSR, exp_main(7'h00));
         `CHK({irq_line_two, irq}, 2'b00)
      end
      pulse(0);
      wr(ADDR_MAIN_CSR, 32'h440, 4'h3, 1'b1);
      chkreg(ADDR_MAIN_CSR, exp_main(7'h04));
      wr(ADDR_IRQ_MASK, 32'h7b, 4'hf);
      repeat (2) @(posedge aclk);
      `CHK({irq_line_two, irq}, 2'b10)
      wr(ADDR_IRQ_MASK, 32'h7f, 4'hf);
      repeat (2) @(posedge aclk);
      `CHK(irq, 1'b1)
      wr(ADDR_IRQ_STAT, 32'h4, 4'hf);
      chkreg(ADDR_IRQ_STAT, 32'h0);
      wr(ADDR_MAIN_CSR, 32'h440, 4'h3);
      internal_loopback <= 1'b1;
      pulse(5);
      internal_loopback <= 1'b0;
      chkreg(ADDR_MAIN_CSR, exp_main(7'h00));
      pulse(6);
      repeat (45) @(posedge aclk);
      chkreg(ADDR_MAIN_CSR, exp_main(7'h20));
      `CHK(irq_line_two, 1'b0)
      wr(ADDR_MAIN_CSR, 32'h2040, 4'h3);
      pulse(6);
      collision_in <= 1'b1;
      @(posedge aclk);
      collision_in <= 1'b0;
      repeat (45) @(posedge aclk);
      chkreg(ADDR_MAIN_CSR, exp_main(7'h00));
      pulse(7);
      pulse(8);
      `CHK({rx_on, tx_on}, 2'b11)
      dma_cycle_active <= 1'b1;
      repeat (600) @(posedge aclk);
      dma_cycle_active <= 1'b0;
      chkreg(ADDR_MAIN_CSR, exp_main(7'h00) | 32'h30);
      stall <= 1'b1;
      dma_cycle_active <= 1'b1;
      repeat (600) @(posedge aclk);
      dma_cycle_active <= 1'b0;
      stall <= 1'b0;
      chkreg(ADDR_MAIN_CSR, exp_main(7'h08));
      wr(ADDR_MAIN_CSR, 32'h840, 4'h3);
      send(12'h5ee, 1'b0);
      chkreg(ADDR_MAIN_CSR, exp_main(7'h00));
      send(12'h5ef, 1'b1);
      chkreg(ADDR_MAIN_CSR, exp_main(7'h40));
      wr(ADDR_MAIN_CSR, 32'h4, 4'h1);
      chkreg(ADDR_MAIN_CSR, 32'h4);
      chkreg(ADDR_IRQ_STAT, 32'h0);
      wr(ADDR_MAIN_CSR, 32'h42, 4'h1);
      pulse(0);
      io_bus_reset <= 1'b1;
      repeat (2) @(posedge aclk);
      io_bus_reset <= 1'b0;
      chkreg(ADDR_MAIN_CSR, 32'h4);
      end_of_test();
   end
endmodule : tb_net_ctrl_status_irq_flags
